// ===== common/drum_map.vh
`ifndef DRUM_MAP_VH
`define DRUM_MAP_VH

// ==================== Register byte addresses ====================
`define ADDR_CTRL       9'h000
`define ADDR_TIMEBASE   9'h004
`define ADDR_MASK       9'h008
`define ADDR_STATUS     9'h00c
`define ADDR_LAST_STEP  9'h010
`define ADDR_CNT_BASE   9'h014
`define ADDR_PAT_BASE   2'h1
`define ADDR_CNTS_BASE  2'h2
`define ADDR_CFG_BASE   2'h3
`define ADDR_CNT_SPACE  1'h1

// ==================== Fields and encodings ====================
`define CTRL_VAR_LSB    0
`define VAR_TIMED       2'h0
`define VAR_TIME_EVENT  2'h1
`define VAR_MASK_BIT    2'h2
`define VAR_MASK_WORD   2'h3
`define MODE_TIME       2'h1
`define MODE_EVENT      2'h2
`define MODE_BOTH       2'h3
`define SRC_INPUT       2'h0
`define SRC_OUTPUT      2'h1
`define SRC_RELAY       2'h2
`define CNT_WORD_ELAPSED 2'h0
`define CNT_WORD_TIMER   2'h1
`define CNT_WORD_PRESET  2'h2
`define CNT_WORD_CURRENT 2'h3

// ==================== Limits and reset values ====================
`define VALUE_MAX       16'h270f
`define STEP_FIRST      5'h01
`define STEP_LAST       5'h10
`define RST_TIMEBASE    16'h0064
`define RST_MASK        16'hffff
`define RST_CNT_BASE    6'h08
`define CNT_BASE_MAX    6'h3c

// ==================== Timing ====================
`define CLK_FREQ_MHZ    20
`define TICK_TIME_US    10000
`define SCAN_TIME_US    1000
`endif

// ===== hdl/drum_step_sequencer.v
// The implementer's own choices: register access over APB and the address map.
`include "drum_map.vh"

module drum_step_sequencer #(
  parameter TICK_CYCLES = `TICK_TIME_US * `CLK_FREQ_MHZ,
  parameter SCAN_CYCLES = `SCAN_TIME_US * `CLK_FREQ_MHZ,
  parameter NSTEP       = 16,
  parameter NOUT        = 16
) (
  input  wire            clk,
  input  wire            resetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [8:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            start_in,
  input  wire            jog_in,
  input  wire            reset_in,
  input  wire [15:0]     in_points,
  input  wire [15:0]     relay_points,
  output reg  [NOUT-1:0] out_points,
  output reg  [NOUT-1:0] out_drive,
  output wire            done
);

  // ==================== Reset release ====================
  reg        rst_meta_reg;
  reg        rst_n_reg;

  // Two stages so release never lands mid-edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==================== State encodings ====================
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // ==================== Storage ====================
  reg [15:0] pat_mem  [0:NSTEP-1];
  reg [15:0] cnts_mem [0:NSTEP-1];
  reg [7:0]  cfg_mem  [0:NSTEP-1];
  reg [1:0]  variant_reg;
  reg [15:0] timebase_reg;
  reg [15:0] mask_reg;
  reg [4:0]  last_step_reg;
  reg [5:0]  cnt_base_reg;
  reg [15:0] preset_reg;
  reg [15:0] elapsed_reg;
  reg [15:0] timer_reg;
  reg [4:0]  cur_step_reg;
  reg        done_reg;
  reg [2:0]  state_reg;
  reg [31:0] tick_cnt_reg;
  reg [31:0] scan_cnt_reg;
  reg [15:0] pend_reg;
  reg        jog_prev_reg;
  reg        jog_pend_reg;
  integer    i;

  // ==================== Timebase and scan enables ====================
  wire tick_en = (tick_cnt_reg == TICK_CYCLES - 1);
  wire scan_en = (scan_cnt_reg == SCAN_CYCLES - 1);

  // Free-running 0.01 s tick and scan strobe
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= 32'h0000_0000;
      scan_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_en ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      scan_cnt_reg <= scan_en ? 32'h0000_0000 : scan_cnt_reg + 32'h0000_0001;
    end
  end

  // Ticks collected between scans; a tick on the scan edge carries over
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_reg <= 16'h0000;
    end else if (scan_en) begin
      pend_reg <= tick_en ? 16'h0001 : 16'h0000;
    end else if (tick_en && pend_reg != 16'hffff) begin
      pend_reg <= pend_reg + 16'h0001;
    end
  end

  // Jog edge caught at clock rate, consumed at scan; new edge wins
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      jog_prev_reg <= 1'b0;
      jog_pend_reg <= 1'b0;
    end else begin
      jog_prev_reg <= jog_in;
      if (jog_in && !jog_prev_reg)
        jog_pend_reg <= 1'b1;
      else if (scan_en)
        jog_pend_reg <= 1'b0;
    end
  end

  // ==================== Step decode ====================
  wire [3:0]  cur_idx  = cur_step_reg[3:0] - 4'h1;
  wire [7:0]  cur_cfg  = cfg_mem[cur_idx];
  wire [15:0] cur_cnts = cnts_mem[cur_idx];
  wire [1:0]  cfg_src  = cur_cfg[5:4];
  wire [3:0]  cfg_pt   = cur_cfg[3:0];
  reg         event_hit;
  reg  [1:0]  step_mode;

  // Event point chosen per step from three point families
  always @* begin
    case (cfg_src)
      `SRC_INPUT:  event_hit = in_points[cfg_pt];
      `SRC_OUTPUT: event_hit = out_points[cfg_pt];
      `SRC_RELAY:  event_hit = relay_points[cfg_pt];
      default:     event_hit = 1'b0;
    endcase
  end

  // Timed variant ignores events; unprogrammed mode falls back to time
  always @* begin
    if (variant_reg == `VAR_TIMED || cur_cfg[7:6] == 2'h0)
      step_mode = `MODE_TIME;
    else
      step_mode = cur_cfg[7:6];
  end

  // ==================== Timing arithmetic ====================
  wire        time_run = (step_mode == `MODE_TIME) ||
                         (step_mode == `MODE_BOTH && event_hit);
  wire [16:0] tmr_sum  = {1'b0, timer_reg} + {1'b0, pend_reg};
  wire        roll     = (tmr_sum >= {1'b0, timebase_reg});
  wire [15:0] tmr_next = roll ? tmr_sum[15:0] - timebase_reg : tmr_sum[15:0];
  wire [15:0] ela_next = roll ? elapsed_reg + 16'h0001 : elapsed_reg;
  wire        cond_met = (step_mode == `MODE_EVENT) ? event_hit :
                         (time_run && ela_next >= cur_cnts);
  wire        at_last  = (cur_step_reg == last_step_reg) ||
                         (cur_step_reg == `STEP_LAST);
  wire        jog_ok   = jog_pend_reg && (variant_reg == `VAR_TIME_EVENT);

  // ==================== Sequencer ====================
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg    <= ST_HOLD;
      cur_step_reg <= `STEP_FIRST;
      elapsed_reg  <= 16'h0000;
      timer_reg    <= 16'h0000;
      done_reg     <= 1'b0;
    end else if (scan_en) begin
      case (state_reg)
        ST_HOLD: begin
          cur_step_reg <= preset_reg[4:0];
          elapsed_reg  <= 16'h0000;
          timer_reg    <= 16'h0000;
          done_reg     <= 1'b0;
          if (!reset_in)
            state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (reset_in) begin
            state_reg    <= ST_HOLD;
            cur_step_reg <= preset_reg[4:0];
            elapsed_reg  <= 16'h0000;
            timer_reg    <= 16'h0000;
          end else if (jog_ok || (start_in && cond_met)) begin
            elapsed_reg <= 16'h0000;
            timer_reg   <= 16'h0000;
            if (at_last) begin
              done_reg  <= 1'b1;
              state_reg <= ST_DONE;
            end else begin
              cur_step_reg <= cur_step_reg + 5'h01;
            end
          end else if (start_in && time_run) begin
            timer_reg   <= tmr_next;
            elapsed_reg <= ela_next;
          end
        end
        ST_DONE: begin
          if (reset_in) begin
            state_reg <= ST_HOLD;
            done_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  assign done = done_reg;

  // ==================== Outputs ====================
  wire masked = (variant_reg == `VAR_MASK_BIT) || (variant_reg == `VAR_MASK_WORD);

  // Pattern follows the step register; one clock behind a step change
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      out_points <= {NOUT{1'b0}};
      out_drive  <= {NOUT{1'b0}};
    end else begin
      out_drive  <= masked ? mask_reg[NOUT-1:0] : {NOUT{1'b1}};
      out_points <= pat_mem[cur_idx][NOUT-1:0] &
                    (masked ? mask_reg[NOUT-1:0] : {NOUT{1'b1}});
    end
  end

  // ==================== APB decode ====================
  wire        setup    = psel && !penable;
  wire        access   = psel && penable;
  wire [1:0]  tbl_sel  = paddr[7:6];
  wire [3:0]  tbl_idx  = paddr[5:2];
  wire        in_cnt   = (paddr[8] == `ADDR_CNT_SPACE);
  wire [5:0]  cnt_off  = paddr[7:2] - cnt_base_reg;
  wire        cnt_hit  = in_cnt && (paddr[7:2] >= cnt_base_reg) && (cnt_off < 6'h04);
  wire        is_tbl   = !in_cnt && (tbl_sel != 2'h0);
  wire        is_ctl   = !in_cnt && (tbl_sel == 2'h0) && (paddr[5:2] <= 4'h5);
  wire        mapped   = (is_tbl || is_ctl || in_cnt) && (paddr[1:0] == 2'h0);
  wire        wr_en    = access && pwrite && mapped;
  wire [15:0] wval     = pwdata[15:0];
  wire        val_ok   = (wval <= `VALUE_MAX);
  wire        step_ok  = (wval >= {11'h000, `STEP_FIRST}) && (wval <= {11'h000, `STEP_LAST});

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // Register writes; out-of-range values are dropped, old value kept
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      variant_reg   <= `VAR_TIMED;
      timebase_reg  <= `RST_TIMEBASE;
      mask_reg      <= `RST_MASK;
      last_step_reg <= `STEP_LAST;
      cnt_base_reg  <= `RST_CNT_BASE;
      preset_reg    <= {11'h000, `STEP_FIRST};
      for (i = 0; i < NSTEP; i = i + 1) begin
        pat_mem[i]  <= 16'h0000;
        cnts_mem[i] <= 16'h0000;
        cfg_mem[i]  <= 8'h00;
      end
    end else if (wr_en) begin
      if (in_cnt) begin
        if (cnt_hit && cnt_off[1:0] == `CNT_WORD_PRESET && step_ok)
          preset_reg <= wval;
      end else begin
        case (tbl_sel)
          `ADDR_PAT_BASE:  pat_mem[tbl_idx] <= wval;
          `ADDR_CNTS_BASE: if (val_ok) cnts_mem[tbl_idx] <= wval;
          `ADDR_CFG_BASE:  cfg_mem[tbl_idx] <= pwdata[7:0];
          default: begin
            case ({1'b0, paddr[7:0]})
              `ADDR_CTRL:      variant_reg <= pwdata[`CTRL_VAR_LSB+1:`CTRL_VAR_LSB];
              `ADDR_TIMEBASE:  if (val_ok && wval != 16'h0000) timebase_reg <= wval;
              `ADDR_MASK:      mask_reg <= wval;
              `ADDR_LAST_STEP: if (step_ok) last_step_reg <= wval[4:0];
              `ADDR_CNT_BASE:  if (pwdata[5:0] <= `CNT_BASE_MAX) cnt_base_reg <= pwdata[5:0];
              default:         variant_reg <= variant_reg;
            endcase
          end
        endcase
      end
    end
  end

  // ==================== APB read ====================
  reg [31:0] rd_mux;

  // Counter words outside the four owned by the sequencer read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (in_cnt) begin
      if (cnt_hit) begin
        case (cnt_off[1:0])
          `CNT_WORD_ELAPSED: rd_mux = {16'h0000, elapsed_reg};
          `CNT_WORD_TIMER:   rd_mux = {16'h0000, timer_reg};
          `CNT_WORD_PRESET:  rd_mux = {16'h0000, preset_reg};
          default:           rd_mux = {27'h0000000, cur_step_reg};
        endcase
      end
    end else begin
      case (tbl_sel)
        `ADDR_PAT_BASE:  rd_mux = {16'h0000, pat_mem[tbl_idx]};
        `ADDR_CNTS_BASE: rd_mux = {16'h0000, cnts_mem[tbl_idx]};
        `ADDR_CFG_BASE:  rd_mux = {24'h000000, cfg_mem[tbl_idx]};
        default: begin
          case ({1'b0, paddr[7:0]})
            `ADDR_CTRL:      rd_mux = {30'h00000000, variant_reg};
            `ADDR_TIMEBASE:  rd_mux = {16'h0000, timebase_reg};
            `ADDR_MASK:      rd_mux = {16'h0000, mask_reg};
            `ADDR_STATUS:    rd_mux = {29'h00000000, state_reg == ST_RUN,
                                       state_reg == ST_HOLD, done_reg};
            `ADDR_LAST_STEP: rd_mux = {27'h0000000, last_step_reg};
            `ADDR_CNT_BASE:  rd_mux = {26'h0000000, cnt_base_reg};
            default:         rd_mux = 32'h0000_0000;
          endcase
        end
      endcase
    end
  end

  // Read data captured in setup so it stands through the access phase
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= rd_mux;
  end

endmodule

// ===== dv/drum_seq_asserts.sv
`include "drum_map.vh"

module drum_seq_checker #(
  parameter NOUT = 16
) (
  input wire            clk,
  input wire            resetn,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [8:0]      paddr,
  input wire [31:0]     prdata,
  input wire            pready,
  input wire            pslverr,
  input wire            start_in,
  input wire            jog_in,
  input wire            reset_in,
  input wire [NOUT-1:0] out_points,
  input wire [NOUT-1:0] out_drive,
  input wire            done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================
  // Bus side
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_zero_wait; psel && penable |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access phase without ready");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
  property p_unmapped; psel && penable && !pwrite && paddr == 9'h018 |-> pslverr && prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read not refused");
  property p_mapped; psel && penable && paddr == `ADDR_TIMEBASE |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  // ========================================
  // Sequencer side; a freeze needs 8 quiet cycles so a latched jog has been consumed
  property p_masked_off; (out_points & ~out_drive) == {NOUT{1'b0}}; endproperty
  a_masked_off: assert property (p_masked_off) else $error("undriven output set");
  property p_done_keeps; done && !reset_in |=> done; endproperty
  a_done_keeps: assert property (p_done_keeps) else $error("done lost without reset");
  property p_done_pattern; done && $past(done) |-> $stable(out_points); endproperty
  a_done_pattern: assert property (p_done_pattern) else $error("pattern moved after done");
  property p_reset_clears; reset_in [*8] |-> !done; endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("done kept in reset");
  property p_frozen; (!start_in && !jog_in && !reset_in) [*8] |-> $stable(out_points); endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved while stopped");
  c_done: cover property ($rose(done));
  c_err: cover property (pslverr);
  c_step: cover property (!done && $changed(out_points));
endmodule

// ===== dv/control_program.sv
module control_program (
  input  wire         clk,
  input  wire  [15:0] ev_in,
  input  wire  [15:0] ev_relay,
  input  wire         run,
  input  wire         hold,
  input  wire         jog_req,
  output logic [15:0] in_points,
  output logic [15:0] relay_points,
  output logic        start_in,
  output logic        reset_in,
  output logic        jog_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================
  // Program scan: points change only after an edge, like a real controller
  always @(posedge clk) begin
    in_points    <= ev_in;
    relay_points <= ev_relay;
    start_in     <= run;
    reset_in     <= hold;
    jog_in       <= jog_req;
  end
endmodule

// ===== dv/tb_top.sv
`include "drum_map.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam SCAN = 4;
  localparam TICK = 10;
  logic        clk, resetn, psel, penable, pwrite, run, hold, jreq, pready, pslverr, e;
  logic        start_in, jog_in, reset_in, done;
  logic [8:0]  paddr;
  logic [31:0] pwdata, prdata, r, xs;
  logic [15:0] in_points, relay_points, out_points, out_drive, ev_in, ev_rel, m, d;
  logic [8:0]  rv_a[6] = '{`ADDR_TIMEBASE, `ADDR_MASK, `ADDR_LAST_STEP, `ADDR_CNT_BASE,
                           9'h128, 9'h12c};
  int          rv_x[6] = '{100, 32'hffff, 16, 8, 1, 1};
  int          errors, checks_done, pat[16], cnt[16], t0, dt, i, k;
  // ========================================
  // Clock and parts
  always #25 clk = ~clk;
  drum_step_sequencer #(.TICK_CYCLES(TICK), .SCAN_CYCLES(SCAN)) drum_step_sequencer_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_in(start_in), .jog_in(jog_in), .reset_in(reset_in), .in_points(in_points),
    .relay_points(relay_points), .out_points(out_points), .out_drive(out_drive), .done(done));
  control_program control_program_i (.clk(clk), .ev_in(ev_in), .ev_relay(ev_rel), .run(run),
    .hold(hold), .jog_req(jreq), .in_points(in_points), .relay_points(relay_points),
    .start_in(start_in), .reset_in(reset_in), .jog_in(jog_in));
  // ========================================
  // Helpers
  function automatic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  // Counter words follow base 5 once it is written
  function automatic [8:0] cw(input int j);
    return {`ADDR_CNT_SPACE, 6'h05 + j[5:0], 2'b00};
  endfunction
  function automatic [8:0] tab(input logic [1:0] b, input int n);
    return {1'b0, b, n[3:0], 2'b00};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll the current step word until it shows s
  task automatic ws(input int s);
    for (int j = 0; j < 300; j++) begin
      apb(0, cw(3), 0);
      if (r[15:0] == s[15:0]) break;
    end
    chk(r, s);
  endtask
  task automatic jog();
    @(posedge clk);
    jreq <= 1'b1;
    repeat (3 * SCAN) @(posedge clk);
    jreq <= 1'b0;
    repeat (3 * SCAN) @(posedge clk);
  endtask
  task automatic endt(input int n);
    $display("test %0d done", n);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ========================================
  // Watchdog, well past the expected few thousand cycles
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
  // ========================================
  // Tests
  initial begin
    clk = 0;
    resetn = 0;
    hold = 1;
    xs = 32'h3909;
    {psel, penable, pwrite, run, jreq} = '0;
    {paddr, pwdata, ev_in, ev_rel} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rv_a[j]) begin
      apb(0, rv_a[j], 0);
      chk(r, rv_x[j]);
    end
    apb(0, `ADDR_STATUS, 0);
    chk(r[0], 0);
    apb(0, 9'h018, 0);
    chk(e, 1);
    chk(r, 0);
    endt(1);
    // Timed run through four steps
    apb(1, `ADDR_CNT_BASE, 5);
    apb(1, `ADDR_TIMEBASE, 32'h270f);
    apb(0, `ADDR_TIMEBASE, 0);
    chk(r, 32'h270f);
    apb(1, `ADDR_TIMEBASE, 32'h2710);
    apb(0, `ADDR_TIMEBASE, 0);
    chk(r, 32'h270f);
    apb(1, `ADDR_TIMEBASE, 3);
    for (k = 0; k < 16; k++) begin
      pat[k] = rnd() & 32'hffff;
      cnt[k] = 2 + k % 3;
      apb(1, tab(`ADDR_PAT_BASE, k), pat[k]);
      apb(1, tab(`ADDR_CNTS_BASE, k), cnt[k]);
      apb(1, tab(`ADDR_CFG_BASE, k), {24'h0, `MODE_TIME, 6'h0});
    end
    apb(1, `ADDR_LAST_STEP, 4);
    apb(1, `ADDR_CTRL, `VAR_TIMED);
    @(posedge clk);
    hold <= 1'b0;
    run <= 1'b1;
    for (k = 1; k <= 4; k++) begin
      ws(k);
      dt = ($time - t0) / 50;
      t0 = $time;
      chk(out_points, pat[k-1]);
      if (k > 1) chk(dt > cnt[k-2]*3*TICK - 24 && dt < cnt[k-2]*3*TICK + 24, 1);
    end
    for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk);
    chk(done, 1);
    repeat (40) @(posedge clk);
    ws(4);
    chk(out_points, pat[3]);
    apb(0, cw(2), 0);
    chk(r, 1);
    endt(2);
    // Reset to a new preset and hold there
    apb(1, cw(2), 3);
    @(posedge clk);
    hold <= 1'b1;
    repeat (2 * SCAN + 2) @(posedge clk);
    chk(done, 0);
    repeat (150) @(posedge clk);
    ws(3);
    chk(out_points, pat[2]);
    apb(0, cw(0), 0);
    chk(r, 0);
    apb(0, cw(1), 0);
    chk(r, 0);
    endt(3);
    // Time-and-event step, then event-only step on a relay point
    apb(1, `ADDR_CTRL, `VAR_TIME_EVENT);
    apb(1, tab(`ADDR_CFG_BASE, 2), {24'h0, `MODE_BOTH, `SRC_INPUT, 4'h5});
    apb(1, tab(`ADDR_CFG_BASE, 3), {24'h0, `MODE_EVENT, `SRC_RELAY, 4'h9});
    @(posedge clk);
    hold <= 1'b0;
    repeat (200) @(posedge clk);
    ws(3);
    apb(0, cw(0), 0);
    chk(r, 0);
    ev_in <= 16'h0020;
    ws(4);
    repeat (150) @(posedge clk);
    ws(4);
    ev_rel <= 16'h0200;
    for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk);
    chk(done, 1);
    endt(4);
    // Jog while stopped, then jog refused in the timed variant
    hold <= 1'b1;
    run <= 1'b0;
    apb(1, cw(2), 1);
    repeat (3 * SCAN) @(posedge clk);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    ws(1);
    jog();
    jog();
    ws(3);
    apb(1, `ADDR_CTRL, `VAR_TIMED);
    jog();
    ws(3);
    endt(5);
    // Output variants with a random mask
    hold <= 1'b1;
    m = rnd();
    apb(1, `ADDR_MASK, m);
    for (k = 0; k < 4; k++) begin
      apb(1, `ADDR_CTRL, k);
      repeat (3 * SCAN) @(posedge clk);
      d = (k >= 2) ? m : 16'hffff;
      chk(out_drive, d);
      chk(out_points, pat[0] & d);
    end
    endt(6);
    stop_test();
  end
endmodule

bind drum_step_sequencer drum_seq_checker #(.NOUT(NOUT)) drum_seq_checker_i (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_in(start_in),
  .jog_in(jog_in), .reset_in(reset_in), .out_points(out_points), .out_drive(out_drive),
  .done(done));
